// [ales_pkg.sv]
/*
  package for the alarm and indicator status encoder: condition flags,
  indicator and monitor carriers, timing constants.
  assumes a single 125 MHz core clock.
*/
`default_nettype none
package ales_pkg;
  localparam int CLK_MHZ          = 125;
  localparam int BLINK_HALF_MS    = 250;  // indicator blink half period
  localparam int PULSE_HALF_MS    = 1;    // power-good pulse half period
  localparam int CYC_PER_MS       = CLK_MHZ * 1000;
  localparam int BLINK_HALF_CYC   = BLINK_HALF_MS * CYC_PER_MS;
  localparam int PULSE_HALF_CYC   = PULSE_HALF_MS * CYC_PER_MS;
  localparam int ADDR_W           = 4;
  localparam logic MON_IDLE       = 1'b1;  // monitor lines idle high
  localparam logic PRESENT_LEVEL  = 1'b0;  // present pin held low

  typedef struct packed {
    logic therm_alarm;
    logic therm_shutdown;
    logic fan_single;
    logic fan_double;
    logic fuse_blown;
    logic boost_fail;
    logic ov_latched;
    logic input_out_of_limits;
    logic input_absent;
    logic overcurrent;
    logic internal_fail;
    logic service_req;
    logic comms_fault;
  } ales_cond_t;

  typedef struct packed {
    logic input_ok;
    logic output_ok;
    logic service;
    logic fault;
  } ales_led_t;

  typedef struct packed {
    logic fault_n;
    logic overheat_warn_n;
    logic output_health_warn_n;
    logic unit_inserted_pin;
  } ales_mon_t;

  typedef enum logic { ALES_PMBUS, ALES_RS485 } ales_proto_t;
endpackage
`default_nettype wire

// [ales_blink.sv]
/*
  square wave generator used for indicator blinking and power-good pulsing.
  assumes core_clk with synchronous active-low reset.
*/
`timescale 1ns/1ns
`default_nettype none
module ales_blink #(
  parameter int HALF_CYC = 4
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  output var  logic wave
);
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic        next_wave;

  // toggle every half period
  always_comb begin
    next_cnt  = cnt + 32'h1;
    next_wave = wave;
    if (cnt >= 32'(HALF_CYC - 1)) begin
      next_cnt  = 32'h0;
      next_wave = ~wave;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt  <= 32'h0;
      wave <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      wave <= next_wave;
    end
  end
endmodule
`default_nettype wire

// [ales_encoder.sv]
/*
  alarm and indicator status encoder: maps condition flags onto four
  front-panel indicators and four monitoring outputs, gates the main
  output and builds the low address bits.
  assumes all inputs are synchronous to core_clk; open-drain pins are
  given as output level plus enable (enable low while driving low).
*/
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// RULE_01 - normal: input and output indicators lit, monitors high, present low
// RULE_02 - thermal alarm: service lit, overheat low; shutdown adds fault outputs
// RULE_03 - fuse, boost or overvoltage: output off, fault lit, fault low
// RULE_04 - input bad: input indicator blinks or off, power-good low
// RULE_05 - overcurrent: output indicator blinks, power-good pulses at 1 ms
// RULE_06 - nonfatal fault: both ok lit, fault lit, fault low, power-good high
// RULE_07 - fan fault: fault lit, fault and power-good low; double shuts down
// RULE_08 - open on/off input is standby: output off, power-good low
// RULE_09 - power-good low whenever main output loss is anticipated
// RULE_10 - fault output idles high, low only in fault condition
// RULE_11 - interlock open keeps main output disabled
// RULE_12 - address bits A3..A0 from unit and shelf position levels
// RULE_13 - present output low in every condition
// RULE_14 - service request or comms fault blink indicators, monitors high; code blinks service in PMBus mode only, fault in RS485 only
module ales_encoder #(
  parameter int BLINK_HALF = ales_pkg::BLINK_HALF_CYC,
  parameter int PULSE_HALF = ales_pkg::PULSE_HALF_CYC
) (
  input  wire logic                            core_clk,
  input  wire logic                            rst_n,
  input  wire ales_pkg::ales_cond_t            cond,
  input  wire ales_pkg::ales_proto_t           proto,
  input  wire logic                            on_off_n,
  input  wire logic                            interlock_made,
  input  wire logic [ales_pkg::ADDR_W-1:0]     unit_position_level,
  input  wire logic [ales_pkg::ADDR_W-1:0]     shelf_position_level,
  output var  ales_pkg::ales_led_t             led,
  output var  ales_pkg::ales_mon_t             mon,
  output var  ales_pkg::ales_mon_t             mon_oe_n,
  output var  logic                            main_enable,
  output var  logic [ales_pkg::ADDR_W-1:0]     addr_low
);
  logic blink;
  logic pulse;
  ales_pkg::ales_led_t next_led;
  ales_pkg::ales_mon_t next_mon;
  logic next_main_enable;
  logic [ales_pkg::ADDR_W-1:0] next_addr_low;
  logic shutdown;
  logic hard_fault;

  ales_blink #(.HALF_CYC(BLINK_HALF)) u_blink (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wave     (blink)
  );

  ales_blink #(.HALF_CYC(PULSE_HALF)) u_pulse (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wave     (pulse)
  );

  // combine the two position levels into the address nibble
  function automatic logic [ales_pkg::ADDR_W-1:0] addr_bits(
    input logic [ales_pkg::ADDR_W-1:0] unit_lvl,
    input logic [ales_pkg::ADDR_W-1:0] shelf_lvl
  );
    addr_bits = unit_lvl ^ shelf_lvl;
  endfunction

  // shutdown causes; a single fan fault keeps running
  assign hard_fault = cond.fuse_blown | cond.boost_fail | cond.ov_latched;
  assign shutdown   = cond.therm_shutdown | hard_fault | cond.fan_double;

  // priority: worst condition last so it overrides milder ones
  always_comb begin
    next_led = '{input_ok: 1'b1, output_ok: 1'b1,
                 service: 1'b0, fault: 1'b0};                    // RULE_01
    next_mon = '{fault_n: ales_pkg::MON_IDLE,
                 overheat_warn_n: ales_pkg::MON_IDLE,
                 output_health_warn_n: ales_pkg::MON_IDLE,
                 unit_inserted_pin: ales_pkg::PRESENT_LEVEL};    // RULE_13
    next_main_enable = !on_off_n && interlock_made;             // RULE_11
    if (proto == ales_pkg::ALES_PMBUS && cond.service_req)
      next_led.service = blink;                                  // RULE_14
    if (proto == ales_pkg::ALES_RS485 && cond.comms_fault)
      next_led.fault = blink;                                    // RULE_14
    if (cond.internal_fail) begin
      next_led.fault   = 1'b1;                                   // RULE_06
      next_mon.fault_n = 1'b0;                                   // RULE_10
    end
    if (cond.overcurrent) begin
      next_led.output_ok = blink;                                // RULE_05
      next_mon.output_health_warn_n = pulse;                     // RULE_05
    end
    if (on_off_n) begin
      next_led.output_ok = 1'b0;                                 // RULE_08
      next_mon.output_health_warn_n = 1'b0;                      // RULE_09
    end
    if (cond.input_out_of_limits || cond.input_absent) begin
      next_led.input_ok  = cond.input_absent ? 1'b0 : blink;     // RULE_04
      next_led.output_ok = 1'b0;
      next_mon.output_health_warn_n = 1'b0;                      // RULE_09
      next_main_enable = 1'b0;
    end
    if (cond.fan_single || cond.fan_double) begin
      next_led.fault   = 1'b1;                                   // RULE_07
      next_mon.fault_n = 1'b0;
      next_mon.output_health_warn_n = 1'b0;
    end
    if (cond.therm_alarm || cond.therm_shutdown) begin
      next_led.service = 1'b1;                                   // RULE_02
      next_mon.overheat_warn_n = 1'b0;
    end
    if (shutdown) begin
      next_led.input_ok  = 1'b1;                                 // RULE_03
      next_led.output_ok = 1'b0;
      next_led.fault     = 1'b1;
      next_mon.fault_n   = 1'b0;                                 // RULE_10
      next_mon.output_health_warn_n = 1'b0;                      // RULE_09
      next_main_enable = 1'b0;
    end
    next_addr_low = addr_bits(unit_position_level,
                              shelf_position_level);             // RULE_12
  end

  // registered outputs; reset turns all indicators off and holds power-good low
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      led         <= '0;
      mon         <= '{fault_n: 1'b1, overheat_warn_n: 1'b1,
                       output_health_warn_n: 1'b0,
                       unit_inserted_pin: 1'b0};
      main_enable <= 1'b0;
      addr_low    <= '0;
    end else begin
      led         <= next_led;
      mon         <= next_mon;
      main_enable <= next_main_enable;
      addr_low    <= next_addr_low;
    end
  end

  // open drain: enable low only while pulling low
  assign mon_oe_n = mon;

  a_present_low: assert property ( // RULE_13
    @(posedge core_clk) disable iff (!rst_n)
    ##1 mon.unit_inserted_pin == 1'b0)
    else $error("present pin not low");
  a_shutdown_out: assert property ( // RULE_03
    @(posedge core_clk) disable iff (!rst_n)
    shutdown |=> !mon.fault_n && !led.output_ok && led.fault)
    else $error("shutdown pattern wrong");
  a_therm_warn: assert property ( // RULE_02
    @(posedge core_clk) disable iff (!rst_n)
    cond.therm_alarm |=> !mon.overheat_warn_n && led.service)
    else $error("thermal warning missing");
  a_standby_pg: assert property ( // RULE_08
    @(posedge core_clk) disable iff (!rst_n)
    on_off_n |=> !mon.output_health_warn_n && !main_enable)
    else $error("standby not reflected");
  a_interlock_gate: assert property ( // RULE_11
    @(posedge core_clk) disable iff (!rst_n)
    !interlock_made |=> !main_enable)
    else $error("main output on without interlock");
  a_fan_fault: assert property ( // RULE_07
    @(posedge core_clk) disable iff (!rst_n)
    cond.fan_single |=> !mon.fault_n && !mon.output_health_warn_n)
    else $error("fan fault not flagged");
  a_input_bad: assert property ( // RULE_04
    @(posedge core_clk) disable iff (!rst_n)
    cond.input_absent && !shutdown |=> !led.input_ok && !led.output_ok)
    else $error("input absent pattern wrong");
  a_addr_bits: assert property ( // RULE_12
    @(posedge core_clk) disable iff (!rst_n)
    ##1 addr_low == $past(unit_position_level ^ shelf_position_level))
    else $error("address bits wrong");
  a_fault_idle: assert property ( // RULE_10
    @(posedge core_clk) disable iff (!rst_n)
    $fell(mon.fault_n) |-> $past(shutdown | cond.fan_single
                                 | cond.internal_fail))
    else $error("fault low without cause");
  a_nonfatal: assert property ( // RULE_06
    @(posedge core_clk) disable iff (!rst_n)
    cond.internal_fail && !shutdown && !cond.fan_single && !on_off_n
    && !cond.input_absent && !cond.input_out_of_limits
    && !cond.overcurrent |=> mon.output_health_warn_n && led.fault)
    else $error("nonfatal fault pattern wrong");
  a_normal: assert property ( // RULE_01
    @(posedge core_clk) disable iff (!rst_n)
    cond == '0 && !on_off_n |=> led.input_ok && led.output_ok
    && !led.service && !led.fault && mon.fault_n
    && mon.overheat_warn_n && mon.output_health_warn_n)
    else $error("normal pattern wrong");

  // overload must not reach the fault pin or the fault lamp
  a_overload_quiet: assert property ( // RULE_05
    @(posedge core_clk) disable iff (!rst_n)
    cond.overcurrent && !shutdown && !cond.fan_single
    && !cond.internal_fail && !cond.comms_fault
    |=> mon.fault_n && !led.fault)
    else $error("overload raised a fault");
  // the pulse wave reaches power-good unless a harder cause holds it low
  a_overload_pulse: assert property ( // RULE_05
    @(posedge core_clk) disable iff (!rst_n)
    cond.overcurrent && !on_off_n && !shutdown && !cond.fan_single
    && !cond.input_out_of_limits && !cond.input_absent
    |=> mon.output_health_warn_n == $past(pulse))
    else $error("power-good not pulsing in overload");
  // standby alone leaves every alarm line released
  a_standby_quiet: assert property ( // RULE_08
    @(posedge core_clk) disable iff (!rst_n)
    on_off_n && cond == '0
    |=> mon.fault_n && mon.overheat_warn_n && !led.output_ok && !led.fault)
    else $error("standby raised an alarm");
  // bad input drops power-good only, the alarm lines stay released
  a_input_alarms: assert property ( // RULE_04
    @(posedge core_clk) disable iff (!rst_n)
    (cond.input_out_of_limits || cond.input_absent) && !shutdown
    && !cond.fan_single && !cond.therm_alarm && !cond.internal_fail
    |=> mon.fault_n && mon.overheat_warn_n && !mon.output_health_warn_n
    && !main_enable)
    else $error("input fault pattern wrong");
  // service blink is a bus-mode feature; thermal warning overrides it
  a_service_blink: assert property ( // RULE_14
    @(posedge core_clk) disable iff (!rst_n)
    cond.service_req && !cond.therm_alarm && !cond.therm_shutdown
    |=> led.service == ($past(proto) == ales_pkg::ALES_PMBUS
                        && $past(blink)))
    else $error("service lamp wrong");
  // comms blink only in the serial-line mode, below every real fault
  a_comms_blink: assert property ( // RULE_14
    @(posedge core_clk) disable iff (!rst_n)
    proto == ales_pkg::ALES_RS485 && cond.comms_fault
    && !cond.internal_fail && !cond.fan_single && !shutdown
    |=> led.fault == $past(blink))
    else $error("comms lamp not blinking");
endmodule
`default_nettype wire

// [ales_shelf_ctrl.sv]
/*
  shelf controller model: pulls up the open-drain monitor lines and
  drives the on/off pin of the unit.
  assumes enables low while the unit sinks a line.
*/
`timescale 1ns/1ns
`default_nettype none
module ales_shelf_ctrl (
  input  wire logic                standby_req,
  input  wire ales_pkg::ales_mon_t mon_oe_n,
  output var  logic                on_off_n,
  output var  ales_pkg::ales_mon_t line
);
  // released lines float to the pull-up, never to the last level
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      line[i] = (mon_oe_n[i] === 1'b0) ? 1'b0 : 1'b1;
    end
    on_off_n = standby_req ? 1'b1 : 1'b0;
  end
endmodule
`default_nettype wire

// [ales_encoder_tb_top.sv]
/*
  self-checking bench for the status encoder: one row per condition.
  assumes short blink and pulse periods so that toggling shows quickly.
*/
`timescale 1ns/1ns
`default_nettype none
module ales_encoder_tb_top;
  logic                  core_clk, rst_n, interlock_made, standby_req;
  logic                  on_off_n, main_enable;
  logic [3:0]            unit_lvl, shelf_lvl, addr_low;
  ales_pkg::ales_cond_t  cond;
  ales_pkg::ales_proto_t proto;
  ales_pkg::ales_led_t   led;
  ales_pkg::ales_mon_t   mon, mon_oe_n, line;
  int                    miscompares, n_checks, seed;
  // per row: leds in/out/svc/flt, lines flt/ot/pg/pres, main enable
  // B means toggling, x means left open by the rules
  // rows 16 and 17 raise each blink request in the mode that ignores it
  string tbl[18] = '{"111010101", "101100000", "1x010100x", "100101000",
    "100101000", "100101000", "100101000", "B00011000", "000011000",
    "1B0011B0x", "110101101", "11B011101", "110B11101", "110011101",
    "100011000", "xxxx1xx00", "110011101", "110011101"};

  ales_encoder #(.BLINK_HALF(4), .PULSE_HALF(2)) ales_encoder_inst (
    .core_clk(core_clk), .rst_n(rst_n), .cond(cond), .proto(proto),
    .on_off_n(on_off_n), .interlock_made(interlock_made),
    .unit_position_level(unit_lvl), .shelf_position_level(shelf_lvl),
    .led(led), .mon(mon), .mon_oe_n(mon_oe_n),
    .main_enable(main_enable), .addr_low(addr_low));
  ales_shelf_ctrl ales_shelf_ctrl_inst (
    .standby_req(standby_req), .mon_oe_n(mon_oe_n),
    .on_off_n(on_off_n), .line(line));

  task automatic chk(input string nm, input logic [3:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // drive one row, watch 14 cycles, keep which levels each bit showed
  task automatic run_case(input int r);
    logic [8:0] obs, ones, zeros;
    logic [3:0] sb, e;
    int rnd;
    string nm;
    ones = '0;
    zeros = '0;
    @(posedge core_clk);
    #1;
    cond = '0;
    if (r < 13) cond[12-r] = 1'b1;
    if (r == 16) cond.service_req = 1'b1;
    if (r == 17) cond.comms_fault = 1'b1;
    proto = (r == 12 || r == 16) ? ales_pkg::ALES_RS485
                                 : ales_pkg::ALES_PMBUS;
    standby_req = (r == 14);
    interlock_made = (r != 15);
    rnd = $random(seed);
    unit_lvl = rnd[3:0];
    shelf_lvl = rnd[7:4];
    repeat (2) @(posedge core_clk);
    repeat (14) begin
      @(posedge core_clk);
      #2;
      obs = {led, line, main_enable};
      chk("mon_pin", mon, line);
      ones |= obs;
      zeros |= ~obs;
    end
    chk("addr_low", addr_low, unit_lvl ^ shelf_lvl);
    for (int j = 0; j < 9; j++) begin
      nm = $sformatf("row%0d_bit%0d", r, j);
      sb = {2'b00, ones[8-j], zeros[8-j]};
      e = (tbl[r][j] == "1") ? 4'h2 : (tbl[r][j] == "0") ? 4'h1 : 4'h3;
      if (tbl[r][j] == "x") continue;
      if (j < 4) chk(nm, sb, e);
      else if (j < 8) chk(nm, sb, e);
      else chk(nm, sb, e);
    end
    $display("test %0d done", r);
  endtask

  // free-running core clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // watchdog sized well above the 18 rows of 17 cycles each
  initial begin
    #(2000 * 8);
    miscompares++;
    end_of_test();
  end

  // main sequence
  initial begin
    seed = 15070;
    rst_n = 1'b0;
    cond = '0;
    proto = ales_pkg::ALES_PMBUS;
    standby_req = 1'b0;
    interlock_made = 1'b1;
    unit_lvl = 4'h0;
    shelf_lvl = 4'h0;
    miscompares = 0;
    n_checks = 0;
    repeat (4) @(posedge core_clk);
    #1;
    chk("rst_led", led, 4'h0);
    chk("rst_line", line, 4'hc);
    rst_n = 1'b1;
    for (int r = 0; r < 18; r++) run_case(r);
    end_of_test();
  end
endmodule
`default_nettype wire
